// file: logic/tli_defs.svh
// named offsets, field positions, response codes and timing figures
// assumes: included by bare name from each design file that needs it
`ifndef TLI_DEFS_SVH
`define TLI_DEFS_SVH
`define TLI_AXI_AW      8
`define TLI_REG_CTRL    8'h00
`define TLI_REG_SUBST   8'h04
`define TLI_REG_CH0     8'h08
`define TLI_REG_CH1     8'h0C
`define TLI_REG_READING 8'h10
`define TLI_REG_CODE0   8'h14
`define TLI_REG_CODE1   8'h18
`define TLI_REG_STATUS  8'h1C
`define TLI_REG_TBL     8'h40
`define TLI_REG_TBL_END 8'hDC
`define TLI_TBL_DEPTH   39
`define TLI_TBL_AW      6
`define TLI_CTRL_OVR    0
`define TLI_CH_INV      15
`define TLI_CH_MASK     16'h8FFF
`define TLI_ST_BUSY     0
`define TLI_ST_LOADED   1
`define TLI_ST_FIRST    2
`define TLI_BASE_IDX    8'h06
`define TLI_DEL_UP1     6'h0D
`define TLI_DEL_DN1     6'h0C
`define TLI_FRAC_W      6
`define TLI_CODE_TOP    12'hFFF
`define TLI_READ_MAX    13'h07FF
`define TLI_READ_MIN    13'h1800
`define TLI_CONV_MS     25
`define TLI_CLK_KHZ     25000
`define TLI_NVM_B0L     6'h27
`define TLI_NVM_B0H     6'h28
`define TLI_NVM_B1L     6'h29
`define TLI_NVM_B1H     6'h2A
`define TLI_NVM_LAST    6'h2A
`define TLI_RESP_OKAY   2'h0
`define TLI_RESP_SLVERR 2'h2
`endif

// file: logic/tli_lut_mem.sv
// two increment tables, one nibble each per word, two registered read ports
// assumes: addresses stay below DEPTH
`timescale 1ns/10ps
`default_nettype none
module tli_lut_mem #(
  parameter int unsigned DEPTH = 39,
  parameter int unsigned DW    = 8
) (
  // clock and enable
  input  wire logic clk,
  input  wire logic ce,
  // access port
  tli_mem_if.mem    port
);
  logic [DW-1:0] mem_r [DEPTH];

  // masked write
  always_ff @(posedge clk) begin
    if (ce && port.wr_en) begin
      mem_r[port.wr_addr] <= (mem_r[port.wr_addr] & ~port.wr_mask) | (port.wr_data & port.wr_mask);
    end
  end

  // compute and bus read ports
  always_ff @(posedge clk) begin
    if (ce) begin
      port.ca_data <= mem_r[port.ca_addr];
      port.ba_data <= mem_r[port.ba_addr];
    end
  end
endmodule // tli_lut_mem
`default_nettype wire

// file: logic/tli_mem_if.sv
// carrier between controller and increment table memory
// assumes: one clock, reads registered in the memory
`timescale 1ns/10ps
`default_nettype none
interface tli_mem_if #(
  parameter int unsigned AW = 6,
  parameter int unsigned DW = 8
);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [DW-1:0] wr_mask;
  logic [AW-1:0] ca_addr;
  logic [DW-1:0] ca_data;
  logic [AW-1:0] ba_addr;
  logic [DW-1:0] ba_data;
  modport ctrl (output wr_en, wr_addr, wr_data, wr_mask, ca_addr, ba_addr,
                input ca_data, ba_data);
  modport mem (input wr_en, wr_addr, wr_data, wr_mask, ca_addr, ba_addr,
               output ca_data, ba_data);
endinterface // tli_mem_if
`default_nettype wire

// file: logic/tli_pkg.sv
// types shared by the interpolator
// assumes: nothing
`default_nettype none
package tli_pkg;
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_NVM   = 8'h02,
    ST_START = 8'h04,
    ST_ADDR  = 8'h08,
    ST_SUM   = 8'h10,
    ST_FADDR = 8'h20,
    ST_FSUM  = 8'h40,
    ST_OUT   = 8'h80
  } tli_state_e;
endpackage
`default_nettype wire

// file: logic/tli_top.sv
// temperature lookup interpolator: axi4-lite registers, nvm copy, two-channel alu
// assumes: sensor code held steady between conversions, nvm read one cycle latent
// Behaviour
// RULE_01 - reading is 12-bit two's complement, 0.0625 C step, msb weighs -128 C
// RULE_02 - reading bytes refresh at every completed conversion, about every 25 ms
// RULE_03 - reading bytes are zero after power-up, first result at 25 ms
// RULE_04 - reading never exceeds 127.9375 C; largest positive code is ceiling
// RULE_05 - table index is reading bits 11 to 6, four degrees per step
// RULE_06 - each table entry is an unsigned 4-bit increment over one interval
// RULE_07 - fixed 24 C reference; channel offset is output code there
// RULE_08 - normal polarity adds increments above reference, subtracts those below
// RULE_09 - low six bits over 64 interpolate a share of the next increment
// RULE_10 - final 12-bit result goes to the channel converter input
// RULE_11 - slope invert set subtracts upper increments, adds lower ones
// RULE_12 - table input is sensor reading or user substitute value in user_substitute_regs
// RULE_13 - two independent tables share the index, each feeds own channel
// RULE_14 - nvm contents copied at power-up, output then produced unprompted
// RULE_15 - below lowest entry, lowest increment extrapolates down the range
// RULE_16 - code is channel offset plus selected increments, anywhere in 12 bits
// RULE_17 - fractional product truncated toward zero; result kept in 12 bits
// RULE_18 - codes recomputed on every new table input, conversion or user_substitute_regs
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "tli_defs.svh"
module tli_top #(
  parameter int unsigned CONV_CYC = `TLI_CONV_MS * `TLI_CLK_KHZ
) (
  // clock, reset, enable
  input  wire logic                   ref_clk,
  input  wire logic                   arst_n,
  input  wire logic                   clk_en,
  // axi4-lite slave
  input  wire logic [`TLI_AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`TLI_AXI_AW-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // sensor front end, unsynchronised
  input  wire logic [12:0]            sensor_raw,
  // non-volatile store read port
  output logic [`TLI_TBL_AW-1:0]      nvm_rd_addr,
  input  wire logic [7:0]             nvm_rd_data,
  // converter input codes
  output logic [11:0]                 converter_input_code0,
  output logic [11:0]                 converter_input_code1
);
  localparam int unsigned CW = $clog2(CONV_CYC + 1);

  logic                  rst_q1_r, rst_n;
  logic [12:0]           sens_q1_r, sens_q2_r;
  tli_pkg::tli_state_e   st_r;
  logic [CW-1:0]         conv_cnt_r;
  logic                  conv_done_r, first_r, pend_r, ld_done_r, wr_trig_r;
  logic [11:0]           reading_r, subst_r, tin, code0_r, code1_r;
  logic                  ovr_r;
  logic [15:0]           ch0_r, ch1_r;
  logic [`TLI_TBL_AW-1:0] nvm_addr_r, ld_waddr_r, walk_r;
  logic                  ld_vld_r, ld_end_r;
  logic [7:0]            idx_diff, mag;
  logic                  up_r;
  logic [5:0]            steps_r, rem_r;
  logic signed [13:0]    acc0_r, acc1_r;
  logic                  awready_r, wready_r, aw_got_r, w_got_r, bvalid_r;
  logic [1:0]            bresp_r, rresp_r, rd_ph_r;
  logic [7:0]            aw_addr_r, ar_addr_r;
  logic [31:0]           wdata_r, rdata_r, rd_word;
  logic [3:0]            wstrb_r;
  logic                  arready_r, rvalid_r, rd_err;
  logic                  aw_hs, w_hs, ar_hs, wr_fire, b_done, trig;

  tli_mem_if #(.AW(`TLI_TBL_AW), .DW(8)) mif ();

  tli_lut_mem #(.DEPTH(`TLI_TBL_DEPTH), .DW(8)) u_mem (
    .clk  (ref_clk),
    .ce   (clk_en),
    .port (mif.mem)
  );

  function automatic logic tbl_hit(input logic [7:0] a);
    return (a >= `TLI_REG_TBL) && (a < `TLI_REG_TBL_END) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [5:0] tbl_idx(input logic [7:0] a);
    logic [7:0] o;
    o = a - `TLI_REG_TBL;
    return o[7:2];
  endfunction

  function automatic logic reg_known(input logic [7:0] a);
    return tbl_hit(a) || (a == `TLI_REG_CTRL) || (a == `TLI_REG_SUBST) ||
           (a == `TLI_REG_CH0) || (a == `TLI_REG_CH1) || (a == `TLI_REG_READING) ||
           (a == `TLI_REG_CODE0) || (a == `TLI_REG_CODE1) || (a == `TLI_REG_STATUS);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] o, input logic [15:0] n,
                                          input logic [1:0] s);
    return {s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
  endfunction

  // share of the next increment, truncated toward zero
  function automatic logic [3:0] frac_part(input logic [5:0] r, input logic [3:0] d);
    logic [9:0] p;
    p = 10'(r) * 10'(d);
    return p[9:`TLI_FRAC_W]; // RULE_09 RULE_17
  endfunction

  // offset plus signed sum, polarity applied, clamped to the code space
  function automatic logic [11:0] chan_code(input logic [15:0] ch, input logic [13:0] acc);
    logic signed [14:0] b, a, s;
    b = $signed({3'h0, ch[11:0]});
    a = $signed({acc[13], acc});
    s = ch[`TLI_CH_INV] ? (b - a) : (b + a); // RULE_08 RULE_11 RULE_16
    if (s < 0) return 12'h000; // RULE_17
    if (s > $signed({3'h0, `TLI_CODE_TOP})) return `TLI_CODE_TOP;
    return s[11:0];
  endfunction

  // reset release through two flops
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      rst_n    <= rst_q1_r;
    end
  end

  // sensor code synchroniser
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sens_q1_r <= '0;
      sens_q2_r <= '0;
    end else if (clk_en) begin
      sens_q1_r <= sensor_raw;
      sens_q2_r <= sens_q1_r;
    end
  end

  // conversion timer and reading bytes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_cnt_r  <= '0;
      conv_done_r <= 1'b0;
      first_r     <= 1'b0;
      reading_r   <= '0; // RULE_03
    end else if (clk_en) begin
      conv_done_r <= 1'b0;
      if (conv_cnt_r == CW'(CONV_CYC - 1)) begin
        conv_cnt_r  <= '0; // RULE_02 RULE_03
        conv_done_r <= 1'b1;
        first_r     <= 1'b1;
        if ($signed(sens_q2_r) > $signed(`TLI_READ_MAX)) begin
          reading_r <= 12'(`TLI_READ_MAX); // RULE_04
        end else if ($signed(sens_q2_r) < $signed(`TLI_READ_MIN)) begin
          reading_r <= 12'(`TLI_READ_MIN); // RULE_01
        end else begin
          reading_r <= sens_q2_r[11:0]; // RULE_01
        end
      end else begin
        conv_cnt_r <= conv_cnt_r + 1'b1;
      end
    end
  end

  assign tin      = ovr_r ? subst_r : reading_r; // RULE_12
  assign idx_diff = {{2{tin[11]}}, tin[11:6]} - `TLI_BASE_IDX; // RULE_05 RULE_07
  assign mag      = idx_diff[7] ? (8'h00 - idx_diff) : idx_diff;
  assign trig     = (conv_done_r && !ovr_r) || wr_trig_r; // RULE_18

  // recompute request, a new trigger wins over the clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= 1'b0;
    end else if (clk_en) begin
      pend_r <= trig || (pend_r && (st_r != tli_pkg::ST_IDLE)); // RULE_18
    end
  end

  // nvm copy sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      nvm_addr_r <= '0;
      ld_waddr_r <= '0;
      ld_vld_r   <= 1'b0;
      ld_end_r   <= 1'b0;
      ld_done_r  <= 1'b0;
    end else if (clk_en) begin
      ld_vld_r   <= (st_r == tli_pkg::ST_NVM) && !ld_end_r;
      ld_waddr_r <= nvm_addr_r;
      if ((st_r == tli_pkg::ST_NVM) && !ld_end_r) begin
        if (nvm_addr_r == `TLI_NVM_LAST) ld_end_r <= 1'b1;
        else nvm_addr_r <= nvm_addr_r + 1'b1;
      end
      if (ld_vld_r && (ld_waddr_r == `TLI_NVM_LAST)) ld_done_r <= 1'b1; // RULE_14
    end
  end

  // main sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= tli_pkg::ST_NVM;
    end else if (clk_en) begin
      unique case (st_r)
        tli_pkg::ST_NVM: begin
          if (ld_vld_r && (ld_waddr_r == `TLI_NVM_LAST)) st_r <= tli_pkg::ST_START; // RULE_14
        end
        tli_pkg::ST_IDLE: begin
          if (pend_r) st_r <= tli_pkg::ST_START; // RULE_18
        end
        tli_pkg::ST_START: begin
          st_r <= (!idx_diff[7] && (mag == 8'h00)) ? tli_pkg::ST_FADDR : tli_pkg::ST_ADDR;
        end
        tli_pkg::ST_ADDR:  st_r <= tli_pkg::ST_SUM;
        tli_pkg::ST_SUM:   st_r <= (steps_r == 6'h01) ? tli_pkg::ST_FADDR : tli_pkg::ST_ADDR;
        tli_pkg::ST_FADDR: st_r <= tli_pkg::ST_FSUM;
        tli_pkg::ST_FSUM:  st_r <= tli_pkg::ST_OUT;
        tli_pkg::ST_OUT:   st_r <= tli_pkg::ST_IDLE;
        default:           st_r <= tli_pkg::ST_IDLE;
      endcase
    end
  end

  // table walker
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      walk_r  <= '0;
      steps_r <= '0;
      up_r    <= 1'b0;
      rem_r   <= '0;
    end else if (clk_en) begin
      if (st_r == tli_pkg::ST_START) begin
        up_r    <= !idx_diff[7];
        steps_r <= mag[5:0];
        rem_r   <= tin[5:0]; // RULE_09
        walk_r  <= idx_diff[7] ? `TLI_DEL_DN1 : `TLI_DEL_UP1; // RULE_07
      end else if (st_r == tli_pkg::ST_SUM) begin
        steps_r <= steps_r - 1'b1;
        if (up_r) begin
          walk_r <= walk_r + 1'b1; // RULE_09
        end else if ((steps_r != 6'h01) && (walk_r != '0)) begin
          walk_r <= walk_r - 1'b1; // RULE_15
        end
      end
    end
  end

  // per-channel accumulators
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc0_r <= '0;
      acc1_r <= '0;
    end else if (clk_en) begin
      unique case (st_r)
        tli_pkg::ST_START: begin
          acc0_r <= '0;
          acc1_r <= '0;
        end
        tli_pkg::ST_SUM: begin
          acc0_r <= up_r ? acc0_r + 14'(mif.ca_data[3:0]) : acc0_r - 14'(mif.ca_data[3:0]); // RULE_06 RULE_08
          acc1_r <= up_r ? acc1_r + 14'(mif.ca_data[7:4]) : acc1_r - 14'(mif.ca_data[7:4]); // RULE_13
        end
        tli_pkg::ST_FSUM: begin
          acc0_r <= acc0_r + 14'(frac_part(rem_r, mif.ca_data[3:0])); // RULE_09
          acc1_r <= acc1_r + 14'(frac_part(rem_r, mif.ca_data[7:4]));
        end
        default: begin
        end
      endcase
    end
  end

  // converter codes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      code0_r <= '0;
      code1_r <= '0;
    end else if (clk_en && (st_r == tli_pkg::ST_OUT)) begin
      code0_r <= chan_code(ch0_r, acc0_r); // RULE_10 RULE_16
      code1_r <= chan_code(ch1_r, acc1_r); // RULE_13
    end
  end

  assign aw_hs   = s_axi_awvalid && awready_r;
  assign w_hs    = s_axi_wvalid && wready_r;
  assign ar_hs   = s_axi_arvalid && arready_r;
  assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
  assign b_done  = bvalid_r && s_axi_bready;

  // axi write channels
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      aw_addr_r <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `TLI_RESP_OKAY;
    end else if (clk_en) begin
      if (aw_hs) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= reg_known(aw_addr_r) ? `TLI_RESP_OKAY : `TLI_RESP_SLVERR;
      end else if (b_done) begin
        bvalid_r <= 1'b0;
      end
      awready_r <= ld_done_r && !aw_hs && !aw_got_r && !wr_fire && (!bvalid_r || s_axi_bready);
      wready_r  <= ld_done_r && !w_hs && !w_got_r && !wr_fire && (!bvalid_r || s_axi_bready);
    end
  end

  // software and nvm written control registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovr_r     <= 1'b0;
      subst_r   <= '0;
      ch0_r     <= '0;
      ch1_r     <= '0;
      wr_trig_r <= 1'b0;
    end else if (clk_en) begin
      wr_trig_r <= wr_fire && reg_known(aw_addr_r); // RULE_18
      if (ld_vld_r) begin
        if (ld_waddr_r == `TLI_NVM_B0L) ch0_r[7:0] <= nvm_rd_data; // RULE_14
        if (ld_waddr_r == `TLI_NVM_B0H) ch0_r[15:8] <= 8'(nvm_rd_data & `TLI_CH_MASK >> 8);
        if (ld_waddr_r == `TLI_NVM_B1L) ch1_r[7:0] <= nvm_rd_data;
        if (ld_waddr_r == `TLI_NVM_B1H) ch1_r[15:8] <= 8'(nvm_rd_data & `TLI_CH_MASK >> 8);
      end
      if (wr_fire) begin
        if ((aw_addr_r == `TLI_REG_CTRL) && wstrb_r[0]) ovr_r <= wdata_r[`TLI_CTRL_OVR]; // RULE_12
        if (aw_addr_r == `TLI_REG_SUBST) subst_r <= 12'(merge16({4'h0, subst_r}, wdata_r[15:0], wstrb_r[1:0]));
        if (aw_addr_r == `TLI_REG_CH0) ch0_r <= merge16(ch0_r, wdata_r[15:0], wstrb_r[1:0]) & `TLI_CH_MASK;
        if (aw_addr_r == `TLI_REG_CH1) ch1_r <= merge16(ch1_r, wdata_r[15:0], wstrb_r[1:0]) & `TLI_CH_MASK;
      end
    end
  end

  // table memory hookup: nvm copy during load, bus writes afterwards
  assign mif.wr_en   = (ld_vld_r && (ld_waddr_r < `TLI_NVM_B0L)) || (wr_fire && tbl_hit(aw_addr_r) && wstrb_r[0]);
  assign mif.wr_addr = ld_vld_r ? ld_waddr_r : tbl_idx(aw_addr_r);
  assign mif.wr_data = ld_vld_r ? nvm_rd_data : wdata_r[7:0];
  assign mif.wr_mask = 8'hFF;
  assign mif.ca_addr = walk_r;
  assign mif.ba_addr = tbl_idx(ar_addr_r);

  // read data select
  always_comb begin
    rd_word = 32'h0;
    rd_err  = 1'b0;
    if (tbl_hit(ar_addr_r)) begin
      rd_word = {24'h0, mif.ba_data};
    end else begin
      case (ar_addr_r)
        `TLI_REG_CTRL:    rd_word[`TLI_CTRL_OVR] = ovr_r;
        `TLI_REG_SUBST:   rd_word[11:0] = subst_r;
        `TLI_REG_CH0:     rd_word[15:0] = ch0_r;
        `TLI_REG_CH1:     rd_word[15:0] = ch1_r;
        `TLI_REG_READING: rd_word[11:0] = reading_r; // RULE_01
        `TLI_REG_CODE0:   rd_word[11:0] = code0_r;
        `TLI_REG_CODE1:   rd_word[11:0] = code1_r;
        `TLI_REG_STATUS: begin
          rd_word[`TLI_ST_BUSY]   = (st_r != tli_pkg::ST_IDLE);
          rd_word[`TLI_ST_LOADED] = ld_done_r;
          rd_word[`TLI_ST_FIRST]  = first_r;
        end
        default:          rd_err = 1'b1;
      endcase
    end
  end

  // axi read channels, two cycles for the registered table read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_r <= 1'b0;
      ar_addr_r <= '0;
      rd_ph_r   <= '0;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= `TLI_RESP_OKAY;
    end else if (clk_en) begin
      rd_ph_r <= {rd_ph_r[0], ar_hs};
      if (ar_hs) ar_addr_r <= s_axi_araddr;
      if (rd_ph_r[1]) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_word;
        rresp_r  <= rd_err ? `TLI_RESP_SLVERR : `TLI_RESP_OKAY;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
      arready_r <= !ar_hs && (rd_ph_r == 2'h0) && (!rvalid_r || s_axi_rready);
    end
  end

  assign s_axi_awready         = awready_r;
  assign s_axi_wready          = wready_r;
  assign s_axi_bvalid          = bvalid_r;
  assign s_axi_bresp           = bresp_r;
  assign s_axi_arready         = arready_r;
  assign s_axi_rvalid          = rvalid_r;
  assign s_axi_rdata           = rdata_r;
  assign s_axi_rresp           = rresp_r;
  assign nvm_rd_addr           = nvm_addr_r;
  assign converter_input_code0 = code0_r;
  assign converter_input_code1 = code1_r;
endmodule // tli_top
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for tli_top through its register bus
// assumes: nvm model on the store port, conversion period shortened
`timescale 1ns/10ps
`default_nettype none
`include "tli_defs.svh"
module tb;
  localparam int unsigned CONV = 400;
  localparam logic [1:0] OK = `TLI_RESP_OKAY;
  logic ref_clk = 0, arst_n = 1, clk_en = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, nvm_rd_data;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [12:0] sensor_raw = 13'h0190;
  logic [5:0] nvm_rd_addr;
  logic [11:0] converter_input_code0, converter_input_code1;
  logic [15:0] c0 = 16'h0800, c1 = 16'h8400;
  logic [11:0] tv [7] = '{12'h180, 12'h1E5, 12'h7FF, 12'h13F, 12'hE40, 12'h800, 12'h17F};
  int num_errors = 0, comparisons = 0;
  always #20 ref_clk = ~ref_clk;
  tli_top #(.CONV_CYC(CONV)) dut (.ref_clk, .arst_n, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sensor_raw, .nvm_rd_addr, .nvm_rd_data,
    .converter_input_code0, .converter_input_code1);
  tli_nvm_model u_nvm (.clk(ref_clk), .addr(nvm_rd_addr), .data(nvm_rd_data));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, OK}, {30'h0, s_axi_bresp});
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    rdr(a);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    chk("rdata", e, rd);
  endtask
  function automatic int ent(input int ch, input int k);
    int j;
    j = (k < 0) ? 0 : k;
    return ch ? 15 - j % 16 : j * 7 % 16;
  endfunction
  function automatic logic [31:0] code(input int ch, input logic [11:0] t, input logic [15:0] cr);
    int idx, s, k;
    idx = $signed(t) >>> 6;
    s = 0;
    for (k = 13; k <= idx + 6; k++) s += ent(ch, k);
    for (k = idx + 7; k <= 12; k++) s -= ent(ch, k);
    s += int'(t[5:0]) * ent(ch, idx + 7) / 64;
    s = cr[15] ? -s : s;
    s += int'(cr[11:0]);
    return (s < 0) ? 32'h0 : (s > 4095) ? 32'hFFF : 32'(s);
  endfunction
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    wrap_up();
  end
  initial begin
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    do rdr(`TLI_REG_STATUS); while (rd[1:0] !== 2'b10);
    rdc(`TLI_REG_READING, 32'h0, OK);
    rdc(`TLI_REG_CODE0, code(0, 12'h000, c0), OK);
    rdc(`TLI_REG_CH0, {16'h0, c0}, OK);
    rdc(`TLI_REG_CH1, {16'h0, c1}, OK);
    rdc(8'h74, 32'h0000002B, OK);
    rdc(8'h20, 32'h0, `TLI_RESP_SLVERR);
    repeat (CONV) @(posedge ref_clk);
    rdc(`TLI_REG_READING, 32'h190, OK);
    rdc(`TLI_REG_CODE1, code(1, 12'h190, c1), OK);
    clk_en <= 1'b0;
    repeat (5) @(posedge ref_clk);
    clk_en <= 1'b1;
    wr(`TLI_REG_CTRL, 32'h1);
    for (int p = 0; p < 2; p++) begin
      if (p == 1) begin
        c0 = 16'h0FFF;
        c1 = 16'h8010;
        wr(`TLI_REG_CH0, {16'h0, c0});
        wr(`TLI_REG_CH1, {16'h0, c1});
      end
      for (int i = 0; i < 7; i++) begin
        wr(`TLI_REG_SUBST, {20'h0, tv[i]});
        repeat (100) @(posedge ref_clk);
        rdc(`TLI_REG_CODE0, code(0, tv[i], c0), OK);
        rdc(`TLI_REG_CODE1, code(1, tv[i], c1), OK);
        chk("code0 pin", code(0, tv[i], c0), {20'h0, converter_input_code0});
        chk("code1 pin", code(1, tv[i], c1), {20'h0, converter_input_code1});
      end
    end
    wr(`TLI_REG_CTRL, 32'h0);
    sensor_raw <= 13'h0FFF;
    repeat (CONV + 120) @(posedge ref_clk);
    rdc(`TLI_REG_READING, 32'h7FF, OK);
    rdc(`TLI_REG_CODE0, code(0, 12'h7FF, c0), OK);
    wrap_up();
  end
endmodule // tb
`default_nettype wire

// file: tb/tli_assertions.sv
// checker for tli_top: bus answers, nvm copy order, reset and freeze of codes
// assumes: bound to tli_top, single ref_clk domain
`timescale 1ns/10ps
`default_nettype none
`include "tli_defs.svh"
module tli_assertions #(
  parameter int unsigned CONV_CYC = 625000
) (
  // clock, reset, enable
  input wire logic                   ref_clk,
  input wire logic                   arst_n,
  input wire logic                   clk_en,
  // register bus
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_awready,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic                   s_axi_bvalid,
  input wire logic [`TLI_AXI_AW-1:0] s_axi_araddr,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic [31:0]            s_axi_rdata,
  input wire logic [1:0]             s_axi_rresp,
  input wire logic                   s_axi_rvalid,
  // store and codes
  input wire logic [5:0]             nvm_rd_addr,
  input wire logic [11:0]            converter_input_code0,
  input wire logic [11:0]            converter_input_code1
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence bad_ar_taken;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h20;
  endsequence
  AST_RST_ZERO: assert property (disable iff (1'b0)
    !arst_n |-> converter_input_code0 == 12'h000 && converter_input_code1 == 12'h000)
    else $error("codes not zero in reset");
  AST_COPY_STEP: assert property (
    nvm_rd_addr != 6'h00 && $changed(nvm_rd_addr) |-> nvm_rd_addr == $past(nvm_rd_addr) + 6'h01)
    else $error("nvm copy skipped an address");
  AST_NO_WRITE_IN_COPY: assert property (
    nvm_rd_addr inside {[6'h01:6'h29]} |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during nvm copy");
  AST_WRITE_ANSWER: assert property (aw_w_taken |-> ##[2:3] s_axi_bvalid)
    else $error("write response late");
  AST_READY_DROP: assert property (aw_w_taken |=> !s_axi_awready && !s_axi_wready)
    else $error("write ready not dropped");
  AST_READ_ANSWER: assert property (
    s_axi_arvalid && s_axi_arready |-> ##[2:3] s_axi_rvalid)
    else $error("read response late");
  AST_BAD_ADDR: assert property (
    bad_ar_taken |-> ##[2:3] s_axi_rvalid && s_axi_rresp == `TLI_RESP_SLVERR && s_axi_rdata == 0)
    else $error("unmapped read not refused");
  AST_FREEZE: assert property (
    !clk_en |=> $stable(converter_input_code0) && $stable(converter_input_code1))
    else $error("codes moved while frozen");
endmodule // tli_assertions
bind tli_top tli_assertions #(.CONV_CYC(CONV_CYC)) u_tli_chk (.ref_clk, .arst_n, .clk_en,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .nvm_rd_addr,
  .converter_input_code0, .converter_input_code1);
`default_nettype wire

// file: tb/tli_nvm_model.sv
// non-volatile store model: two tables and channel words, one cycle read
// assumes: read on rising ref_clk, address held by the reader
`timescale 1ns/10ps
`default_nettype none
module tli_nvm_model (
  // clock
  input  wire logic       clk,
  // read port
  input  wire logic [5:0] addr,
  output logic      [7:0] data
);
  always_ff @(posedge clk) begin
    case (addr)
      6'h27:   data <= 8'h00;
      6'h28:   data <= 8'h08;
      6'h29:   data <= 8'h00;
      6'h2A:   data <= 8'h84;
      default: data <= (addr < 6'h27) ? {4'(15 - addr % 16), 4'(addr * 7 % 16)} : ~data;
    endcase
  end
endmodule // tli_nvm_model
`default_nettype wire
